// ==== core/timer_pkg.sv ====
// constants shared by the prescaled down timer and its self-checking bench
package timer_pkg;
    localparam int CNT_W = 8;
    localparam int PRE_W = 7;
    localparam int TAP_W = 3;
    localparam int DIV_W = 4;
    localparam int ADDR_W = 8;
    localparam logic [DIV_W-1:0] INT_DIV_LAST = 4'hb; // internal clock divided by 12
    localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
    localparam logic [DIV_W-1:0] DIV_STEP = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALER = 8'hd2;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER = 8'hd3;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'hd4;
    localparam logic [PRE_W-1:0] PRE_RESET = 7'h7f;
    localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
    localparam logic [PRE_W-1:0] PRE_STEP = 7'h01;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
    localparam logic [CNT_W-1:0] CTL_RESET = 8'h00;
    localparam logic [CNT_W-1:0] RD_ZERO = 8'h00;
    // control/status bit positions
    localparam int BIT_ZERO_FLAG = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_DIR = 5;
    localparam int BIT_DOUT = 4;
    localparam int BIT_RUN = 3;
    localparam int BIT_TAP_HI = 2;
    localparam int BIT_TAP_LO = 0;
    // operating mode from {direction, data}
    typedef enum logic [1:0] {
        MODE_EVENT = 2'b00,
        MODE_GATED = 2'b01,
        MODE_OUTPUT = 2'b10
    } mode_e;
endpackage : timer_pkg

// ==== core/pin_if.sv ====
// synchronised timer pin level and rising edge
`timescale 1ns/10ps
interface pin_if;
    logic level;
    logic rise;
    modport sync_side (output level, output rise);
    modport user_side (input level, input rise);
endinterface : pin_if

// ==== core/pin_sync.sv ====
// two-flop synchroniser with rising edge detect for the timer pin
`timescale 1ns/10ps
module pin_sync (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pin_raw,
    pin_if.sync_side pin
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    // the edge detector reads only the second and third stages
    always_comb begin
        meta_d = pin_raw;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // reset to the pulled-up idle level, so that release brings no false rising edge
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign pin.level = sync_q;
    assign pin.rise = sync_q & ~prev_q;
endmodule : pin_sync

// ==== core/prescaled_down_timer.sv ====
// 8-bit free running downcounter behind a 7-bit prescaler, with register port
`timescale 1ns/10ps
// Contract
// - prescaler input is internal clock over 12 or pin clock, rising edges
// - prescaler reaching zero reloads 7Fh and keeps counting
// - prescaler value is readable through the prescaler register
// - 8-bit counter decrements once per count clock from the chosen tap
// - counter reaching zero reloads 0FFh and keeps running
// - counter register readable and writable anytime; write replaces value
// - tap select picks prescaler input divided by 2 to the n
// - run bit clear freezes counter, holds prescaler at 7Fh
// - reset sets counter to 0FFh and prescaler to 7Fh
// - with run set, software may write 0 to 7Fh into prescaler
// - decrement to zero sets zero flag; with enable, raise interrupt
// - writing 00h to counter or one to control bit 7 sets flag
// - counter write beats simultaneous decrement to zero; flag not set
// - direction and data bits select event, gated or output mode
// - gated mode counts internal clock over 12 only while pin high
// - event mode counts every rising edge of the pin
// - output mode uses clock over 12; flag rise latches data to pin
// - direction set makes the pin a push-pull output at once
// - wait leaves timer running; timer interrupt wakes from wait or stop
// - stop freezes registers except in event mode
// - control register at 0D4h holds flag, enable, dir, data, run, tap
// - prescaler register at 0D2h, bit 7 reads zero
// - counter register at 0D3h holds all eight bits
module prescaled_down_timer (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_pkg::CNT_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [timer_pkg::CNT_W-1:0] rdata_q,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic timer_pin_in,
    output logic timer_pin_out_q,
    output logic timer_pin_oe_q,
    output logic irq_q
);
    pin_if pin ();

    logic [timer_pkg::DIV_W-1:0] div_q, div_d;
    logic [timer_pkg::PRE_W-1:0] pre_q, pre_d;
    logic [timer_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic zero_flag_q, zero_flag_d;
    logic zero_irq_enable_q, zero_irq_enable_d;
    logic pin_direction_bit_q, pin_direction_bit_d;
    logic pin_data_bit_q, pin_data_bit_d;
    logic prescaler_run_q, prescaler_run_d;
    logic [timer_pkg::TAP_W-1:0] tap_select_q, tap_select_d;
    logic out_latch_q, out_latch_d;
    logic pin_oe_d, irq_d;
    logic [timer_pkg::CNT_W-1:0] rdata_d;
    timer_pkg::mode_e mode;
    logic frozen, int_tick, pre_tick, cnt_tick, underflow;
    logic wr_pre, wr_cnt, wr_ctl;
    logic [timer_pkg::PRE_W-1:0] tap_mask;
    logic [timer_pkg::CNT_W-1:0] tap_span;

    // pin arrives asynchronously, so it is synchronised before any use
    pin_sync u_pin_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_raw(timer_pin_in),
        .pin(pin.sync_side)
    );

    // register port decode
    always_comb begin
        wr_pre = wr_stb && (addr == timer_pkg::ADDR_PRESCALER);
        wr_cnt = wr_stb && (addr == timer_pkg::ADDR_COUNTER);
        wr_ctl = wr_stb && (addr == timer_pkg::ADDR_CONTROL);
    end

    // mode select and clock source
    always_comb begin
        if (pin_direction_bit_q) begin
            mode = timer_pkg::MODE_OUTPUT;
        end else if (pin_data_bit_q) begin
            mode = timer_pkg::MODE_GATED;
        end else begin
            mode = timer_pkg::MODE_EVENT;
        end
        frozen = stop_mode && (mode != timer_pkg::MODE_EVENT);
        int_tick = (div_q == timer_pkg::INT_DIV_LAST) && !frozen;
        unique case (mode)
            timer_pkg::MODE_EVENT: pre_tick = pin.rise;
            timer_pkg::MODE_GATED: pre_tick = int_tick && pin.level;
            default: pre_tick = int_tick;
        endcase
        // tap divides by 2 to the n
        // computed at counter width so that tap 7 cannot overflow, then cut to 7 bits
        tap_span = (timer_pkg::CNT_STEP << tap_select_q) - timer_pkg::CNT_STEP;
        tap_mask = tap_span[timer_pkg::PRE_W-1:0];
        cnt_tick = prescaler_run_q && pre_tick && ((pre_q & tap_mask) == timer_pkg::PRE_ZERO);
    end

    // internal clock divided by 12; only the prescaler input uses it
    always_comb begin
        if (frozen) begin
            div_d = div_q;
        end else if (div_q == timer_pkg::INT_DIV_LAST) begin
            div_d = timer_pkg::DIV_ZERO;
        end else begin
            div_d = div_q + timer_pkg::DIV_STEP;
        end
    end

    // prescaler: run clear holds 7Fh, write only while running
    always_comb begin
        pre_d = pre_q;
        if (frozen) begin
            pre_d = pre_q;
        end else if (!prescaler_run_q) begin
            pre_d = timer_pkg::PRE_RESET;
        end else if (wr_pre) begin
            pre_d = wdata[timer_pkg::PRE_W-1:0];
        end else if (pre_tick) begin
            if (pre_q == timer_pkg::PRE_ZERO) begin
                pre_d = timer_pkg::PRE_RESET;
            end else begin
                pre_d = pre_q - timer_pkg::PRE_STEP;
            end
        end
    end

    // counter: a software write beats a same-cycle decrement
    always_comb begin
        cnt_d = cnt_q;
        underflow = 1'b0;
        if (wr_cnt) begin
            cnt_d = wdata;
        end else if (cnt_tick) begin
            if (cnt_q == timer_pkg::CNT_ZERO) begin
                cnt_d = timer_pkg::CNT_RESET;
            end else begin
                cnt_d = cnt_q - timer_pkg::CNT_STEP;
            end
            underflow = (cnt_d == timer_pkg::CNT_ZERO);
        end
    end

    // control/status bits, zero flag and pin latch
    always_comb begin
        zero_irq_enable_d = zero_irq_enable_q;
        pin_direction_bit_d = pin_direction_bit_q;
        pin_data_bit_d = pin_data_bit_q;
        prescaler_run_d = prescaler_run_q;
        tap_select_d = tap_select_q;
        zero_flag_d = zero_flag_q;
        if (wr_ctl) begin
            zero_flag_d = wdata[timer_pkg::BIT_ZERO_FLAG];
            zero_irq_enable_d = wdata[timer_pkg::BIT_IRQ_EN];
            pin_direction_bit_d = wdata[timer_pkg::BIT_DIR];
            pin_data_bit_d = wdata[timer_pkg::BIT_DOUT];
            prescaler_run_d = wdata[timer_pkg::BIT_RUN];
            tap_select_d = wdata[timer_pkg::BIT_TAP_HI:timer_pkg::BIT_TAP_LO];
        end
        if (wr_cnt && (wdata == timer_pkg::CNT_ZERO)) begin
            zero_flag_d = 1'b1;
        end
        if (underflow) begin
            zero_flag_d = 1'b1;
        end
        out_latch_d = out_latch_q;
        if (zero_flag_d && !zero_flag_q) begin
            out_latch_d = pin_data_bit_q;
        end
        pin_oe_d = pin_direction_bit_d;
        // same level serves as wake request
        irq_d = zero_flag_d && zero_irq_enable_d;
    end

    // read data stands the cycle after the strobe; unmapped reads zero
    always_comb begin
        rdata_d = timer_pkg::RD_ZERO;
        if (rd_stb) begin
            unique case (addr)
                timer_pkg::ADDR_PRESCALER: rdata_d = {1'b0, pre_q};
                timer_pkg::ADDR_COUNTER: rdata_d = cnt_q;
                timer_pkg::ADDR_CONTROL: rdata_d = {zero_flag_q, zero_irq_enable_q,
                    pin_direction_bit_q, pin_data_bit_q, prescaler_run_q, tap_select_q};
                default: rdata_d = timer_pkg::RD_ZERO;
            endcase
        end
    end

    // state registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            div_q <= timer_pkg::DIV_ZERO;
            pre_q <= timer_pkg::PRE_RESET;
            cnt_q <= timer_pkg::CNT_RESET;
            zero_flag_q <= timer_pkg::CTL_RESET[timer_pkg::BIT_ZERO_FLAG];
            zero_irq_enable_q <= timer_pkg::CTL_RESET[timer_pkg::BIT_IRQ_EN];
            pin_direction_bit_q <= timer_pkg::CTL_RESET[timer_pkg::BIT_DIR];
            pin_data_bit_q <= timer_pkg::CTL_RESET[timer_pkg::BIT_DOUT];
            prescaler_run_q <= timer_pkg::CTL_RESET[timer_pkg::BIT_RUN];
            tap_select_q <= timer_pkg::CTL_RESET[timer_pkg::BIT_TAP_HI:timer_pkg::BIT_TAP_LO];
            out_latch_q <= 1'b0;
            timer_pin_oe_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= timer_pkg::RD_ZERO;
        end else begin
            div_q <= div_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            zero_flag_q <= zero_flag_d;
            zero_irq_enable_q <= zero_irq_enable_d;
            pin_direction_bit_q <= pin_direction_bit_d;
            pin_data_bit_q <= pin_data_bit_d;
            prescaler_run_q <= prescaler_run_d;
            tap_select_q <= tap_select_d;
            out_latch_q <= out_latch_d;
            timer_pin_oe_q <= pin_oe_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    // pin data is the latch itself, so it is a flop output as well
    assign timer_pin_out_q = out_latch_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_prescaler_held: assert property (!prescaler_run_q && !frozen
        |=> pre_q == timer_pkg::PRE_RESET)
        else $error("prescaler not held at 7Fh while run clear");

    a_counter_frozen: assert property (!prescaler_run_q && !wr_cnt |=> $stable(cnt_q))
        else $error("counter moved while run clear");

    a_zero_flag_set: assert property (cnt_tick && !wr_cnt
        && cnt_q == timer_pkg::CNT_STEP |=> zero_flag_q)
        else $error("zero flag missing after decrement to zero");

    a_write_wins: assert property (wr_cnt |=> cnt_q == $past(wdata))
        else $error("counter write did not take effect");

    a_counter_reload: assert property (cnt_tick && !wr_cnt
        && cnt_q == timer_pkg::CNT_ZERO |=> cnt_q == timer_pkg::CNT_RESET)
        else $error("counter did not reload 0FFh");

    a_flag_set_wins: assert property (underflow && wr_ctl
        && !wdata[timer_pkg::BIT_ZERO_FLAG] |=> zero_flag_q)
        else $error("underflow lost to software clear");

    a_out_latch: assert property ($rose(zero_flag_q)
        |-> timer_pin_out_q == $past(pin_data_bit_q))
        else $error("pin data not latched on zero flag rise");

    a_pin_enable: assert property ($rose(pin_direction_bit_q) |-> timer_pin_oe_q)
        else $error("pin not driven after direction set");

    a_irq_gate: assert property (zero_flag_q && zero_irq_enable_q |-> irq_q)
        else $error("interrupt request missing");

    a_reserved_bit: assert property (rd_stb && addr == timer_pkg::ADDR_PRESCALER
        |=> !rdata_q[timer_pkg::BIT_ZERO_FLAG] && rdata_q[timer_pkg::PRE_W-1:0] == $past(pre_q))
        else $error("prescaler read back wrong");

    a_stop_freeze: assert property (frozen && !wr_stb
        |=> $stable(cnt_q) && $stable(pre_q))
        else $error("registers moved in stop outside event mode");

    a_divider_range: assert property (div_q <= timer_pkg::INT_DIV_LAST)
        else $error("internal divider left its range");

    a_prescaler_step: assert property (prescaler_run_q && !frozen && !wr_pre && pre_tick
        && pre_q != timer_pkg::PRE_ZERO |=> pre_q == $past(pre_q) - timer_pkg::PRE_STEP)
        else $error("prescaler did not step down");

    a_prescaler_reload: assert property (prescaler_run_q && !frozen && !wr_pre
        && pre_tick && pre_q == timer_pkg::PRE_ZERO |=> pre_q == timer_pkg::PRE_RESET)
        else $error("prescaler did not reload 7Fh");

    a_prescaler_load: assert property (wr_pre && prescaler_run_q && !frozen
        |=> pre_q == $past(wdata[timer_pkg::PRE_W-1:0]))
        else $error("prescaler write did not take effect");

    a_counter_idle: assert property (!cnt_tick && !wr_cnt |=> $stable(cnt_q))
        else $error("counter moved without a count clock");

    a_counter_step: assert property (cnt_tick && !wr_cnt
        && cnt_q != timer_pkg::CNT_ZERO |=> cnt_q == $past(cnt_q) - timer_pkg::CNT_STEP)
        else $error("counter did not step down");

    a_flag_by_write: assert property (wr_cnt && wdata == timer_pkg::CNT_ZERO
        |=> zero_flag_q)
        else $error("zero flag missing after a counter write of zero");

    a_write_no_flag: assert property (wr_cnt && wdata != timer_pkg::CNT_ZERO
        && !zero_flag_q |=> !zero_flag_q)
        else $error("zero flag set although a counter write took precedence");

    a_gate_closed: assert property (mode == timer_pkg::MODE_GATED && !pin.level
        |-> !pre_tick)
        else $error("prescaler ticked in gated mode with the pin low");

    a_wait_running: assert property (wait_mode && !stop_mode |-> !frozen)
        else $error("timer frozen in wait");
endmodule : prescaled_down_timer

// ==== test/pin_partner.sv ====
// behavioural far-side source for the timer pin, with the port pull-up
`timescale 1ns/10ps
module pin_partner (
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic pin_level
);
    // pulled up input
    // a released line floats to the pull-up; the timer output wins while enabled
    assign pin_level = pin_oe ? pin_out : (drive_en ? drive_val : 1'b1);
endmodule : pin_partner

// ==== test/prescaled_down_timer_bench.sv ====
// self-checking bench for the prescaled down timer
`timescale 1ns/10ps
module prescaled_down_timer_bench;
    localparam logic [7:0] pre_a = timer_pkg::ADDR_PRESCALER;
    localparam logic [7:0] cnt_a = timer_pkg::ADDR_COUNTER;
    localparam logic [7:0] ctl_a = timer_pkg::ADDR_CONTROL;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic drive_en = 1'b0;
    logic drive_val = 1'b0;
    logic [7:0] rdata_q;
    logic pin_level;
    logic pin_out;
    logic pin_oe;
    logic irq;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    prescaled_down_timer dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .timer_pin_in(pin_level), .timer_pin_out_q(pin_out),
        .timer_pin_oe_q(pin_oe), .irq_q(irq));

    pin_partner far_side (.drive_en(drive_en), .drive_val(drive_val), .pin_oe(pin_oe),
        .pin_out(pin_out), .pin_level(pin_level));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 d = rdata_q;
    endtask : rd

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(what, exp, d);
    endtask : rd_chk

    // pins after registered outputs have settled: {out, enable, irq}
    task automatic pins(input logic [2:0] exp);
        idle(2);
        #1 chk("pins", {5'h00, exp}, {5'h00, pin_out, pin_oe, irq});
    endtask : pins

    task automatic pulse(input int len);
        @(posedge ref_clk);
        drive_val <= 1'b1;
        idle(len);
        drive_val <= 1'b0;
        idle(len);
    endtask : pulse

    // reset values and an unmapped read
    task automatic t_reset();
        rd_chk("prescaler", pre_a, 8'h7f);
        rd_chk("counter", cnt_a, 8'hff);
        rd_chk("control", ctl_a, 8'h00);
        rd_chk("unmapped", 8'hd5, 8'h00);
    endtask : t_reset

    // run bit clear: frozen, prescaler held, counter still writable
    task automatic t_frozen();
        wr(ctl_a, 8'h20);
        pins(3'b010);
        wr(pre_a, 8'h11);
        idle(30);
        rd_chk("held counter", cnt_a, 8'hff);
        rd_chk("held prescaler", pre_a, 8'h7f);
        wr(cnt_a, 8'h5a);
        rd_chk("counter write", cnt_a, 8'h5a);
    endtask : t_frozen

    // pin edges clock the prescaler, even in stop
    task automatic t_event();
        @(posedge ref_clk);
        drive_en <= 1'b1;
        wr(ctl_a, 8'h08);
        wr(pre_a, 8'h85);
        rd_chk("prescaler write", pre_a, 8'h05);
        wr(cnt_a, 8'h10);
        stop_mode <= 1'b1;
        pulse(3);
        pulse(5);
        pulse(20);
        stop_mode <= 1'b0;
        rd_chk("event prescaler", pre_a, 8'h02);
        rd_chk("event counter", cnt_a, 8'h0d);
    endtask : t_event

    // stop freezes the internally clocked mode
    task automatic t_stop();
        logic [7:0] c;
        // a read returns just after an edge, so realign before driving levels
        @(posedge ref_clk);
        stop_mode <= 1'b1;
        wr(ctl_a, 8'h28);
        rd(cnt_a, c);
        idle(60);
        rd_chk("stop counter", cnt_a, c);
        @(posedge ref_clk);
        stop_mode <= 1'b0;
    endtask : t_stop

    // spacing of counter steps is 12 times two to the tap, in wait
    task automatic t_taps();
        logic [7:0] prev;
        logic [7:0] d;
        int t0;
        int gap;
        logic [7:0] seen;
        wait_mode <= 1'b1;
        // all eight taps; tap 7 needs about 1540 reads for two steps
        for (int n = 0; n < 8; n++) begin
            wr(ctl_a, 8'h28 | 8'(n));
            wr(cnt_a, 8'hf0);
            wr(pre_a, 8'h7f);
            rd(cnt_a, prev);
            t0 = -1;
            gap = 0;
            // even sampling pitch keeps both detections at the same lag
            for (int c = 0; c < 1700 && gap == 0; c++) begin
                rd(cnt_a, d);
                if (d !== prev) begin
                    if (t0 < 0) begin
                        t0 = cycles;
                    end else begin
                        gap = cycles - t0;
                    end
                    prev = d;
                end
            end
            seen = (gap % 12 == 0) ? 8'(gap / 12) : 8'hee;
            chk("tap step", 8'(1 << n), seen);
        end
        @(posedge ref_clk);
        wait_mode <= 1'b0;
    endtask : t_taps

    // zero flag sources, interrupt, mask and pin latch
    task automatic t_zero();
        wr(ctl_a, 8'h70);
        wr(cnt_a, 8'h00);
        pins(3'b111);
        rd_chk("flag by write", ctl_a, 8'hf0);
        wr(ctl_a, 8'h60);
        pins(3'b110);
        wr(cnt_a, 8'h02);
        wr(ctl_a, 8'h68);
        for (int i = 0; i < 60 && irq !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("underflow", 8'h01, {6'h00, pin_out, irq});
        rd_chk("at zero", cnt_a, 8'h00);
        idle(12);
        rd_chk("reload", cnt_a, 8'hff);
        wr(ctl_a, 8'h68);
        pins(3'b010);
        wr(ctl_a, 8'he0);
        pins(3'b011);
        wr(ctl_a, 8'ha0);
        pins(3'b010);
        rd_chk("masked", ctl_a, 8'ha0);
    endtask : t_zero

    // gated: internal ticks only while the pin is high
    task automatic t_gated();
        logic [7:0] c1;
        logic [7:0] c2;
        @(posedge ref_clk);
        drive_val <= 1'b0;
        wr(cnt_a, 8'h40);
        wr(ctl_a, 8'h18);
        idle(40);
        rd_chk("gate low", cnt_a, 8'h40);
        @(posedge ref_clk);
        drive_val <= 1'b1;
        idle(8);
        rd(cnt_a, c1);
        idle(46);
        rd(cnt_a, c2);
        chk("gate high", c1 - 8'h04, c2);
    endtask : t_gated

    initial begin
        idle(16);
        rst_b <= 1'b1;
        t_reset();
        t_frozen();
        t_event();
        t_stop();
        t_taps();
        t_zero();
        t_gated();
        give_verdict();
    end
endmodule : prescaled_down_timer_bench
